// [core/ddrl_pkg.sv]
// shared constants and types for the ddr4 data lane and alert logic
package ddrl_pkg;

    // =========================================================
    // burst layout
    localparam int unsigned BURST_BEATS = 8;
    localparam int unsigned DATA_PAIRS = BURST_BEATS / 2;
    localparam int unsigned CRC_PAIRS = 1;
    localparam int unsigned PAIR_AW = 2;

    // =========================================================
    // write crc (8 bit, serial form)
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'hff;

    // =========================================================
    // alert timing in core clock cycles
    localparam int unsigned ALERT_PULSE_CYC = 6;
    localparam int unsigned PAR_RECOVER_CYC = 16;
    localparam int unsigned ALERT_CNT_W = 8;

    // =========================================================
    // pin field widths
    localparam int unsigned CA_ADDR_BITS = 17;
    localparam int unsigned SA_BITS = 3;
    localparam int unsigned VREF_MON_BITS = 4;
    localparam int unsigned PIN_SYNC_W = 40;
    localparam int unsigned LINK_SYNC_W = 4;

    // =========================================================
    // values after reset
    localparam logic DQS_RESET = 1'b0;
    localparam logic OE_N_RESET = 1'b1;
    localparam logic EVENT_N_RESET = 1'b1;

    // =========================================================
    // alert pin states
    typedef enum logic [1:0] {
        AL_IDLE,
        AL_CRC,
        AL_PAR
    } ddrl_alert_st_t;

endpackage : ddrl_pkg

// [core/ddrl_pair_mem.sv]
// small two-clock memory holding the beat pairs of one write burst
`timescale 1ns/1ns
module ddrl_pair_mem #(
    parameter int unsigned DW = 18,
    parameter int unsigned AW = 2
) (
    // write side, link strobe falling edge
    input wire logic wclk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    // read side, core clock
    input wire logic rclk_i,
    input wire logic rarst_n_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);

    // =========================================================
    // storage
    logic [DW-1:0] mem_q [2**AW];

    // written on the falling strobe edge, where the odd beat is sampled
    always_ff @(negedge wclk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // registered read; software reads only after the done pulse, so no overlap
    always_ff @(posedge rclk_i or negedge rarst_n_i) begin
        if (!rarst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem_q[raddr_i];
        end
    end

endmodule : ddrl_pair_mem

// [core/ddrl_lane.sv]
// ddr4 data lane: write capture with mask, inversion and crc, read drive, alert pin
`timescale 1ns/1ns

module ddrl_lane #(
    parameter int unsigned W = 8,
    parameter int unsigned ALERT_CYC = ddrl_pkg::ALERT_PULSE_CYC,
    parameter int unsigned RECOV_CYC = ddrl_pkg::PAR_RECOVER_CYC,
    localparam int unsigned NL = (W == 16) ? 2 : 1,
    localparam int unsigned LW = W / NL,
    localparam int unsigned PDW = 2 * (W + NL)
) (
    // clocks and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic dqs_clk_i,
    // data pins
    input wire logic [W-1:0] dq_i,
    output logic [W-1:0] dq_o,
    output logic [W-1:0] dq_oe_n_o,
    // shared mask / inversion pins, one per byte lane
    input wire logic [NL-1:0] dm_dbi_i,
    output logic [NL-1:0] dm_dbi_o,
    output logic dm_dbi_oe_n_o,
    // strobe output pairs
    output logic [NL-1:0] dqs_t_o,
    output logic [NL-1:0] dqs_c_o,
    output logic dqs_oe_n_o,
    // mode settings
    input wire logic mr5_dm_en_i,
    input wire logic mr5_wdbi_en_i,
    input wire logic mr5_rdbi_en_i,
    input wire logic mr1_tdqs_en_i,
    input wire logic wr_crc_en_i,
    input wire logic mr4_vref_mon_i,
    input wire logic [ddrl_pkg::VREF_MON_BITS-1:0] vref_level_i,
    input wire logic mr5_par_en_i,
    input wire logic ct_mode_i,
    // read data from the array, core clock
    input wire logic rd_valid_i,
    input wire logic [W-1:0] rd_data_i,
    // write burst results
    output logic wr_done_o,
    output logic wr_crc_err_o,
    input wire logic [ddrl_pkg::PAIR_AW-1:0] wr_pair_addr_i,
    output logic [PDW-1:0] wr_pair_data_o,
    // command / address pins
    input wire logic ca_cs_n_i,
    input wire logic ca_act_n_i,
    input wire logic [1:0] ca_bg_i,
    input wire logic [1:0] ca_ba_i,
    input wire logic [ddrl_pkg::CA_ADDR_BITS-1:0] ca_addr_i,
    input wire logic ca_par_i,
    output logic cmd_valid_o,
    output logic par_err_o,
    // alert pin, open drain
    input wire logic alert_i,
    output logic alert_o,
    output logic alert_oe_n_o,
    output logic alert_seen_o,
    // sensor and spd address
    input wire logic temp_crit_i,
    output logic event_n_o,
    input wire logic [ddrl_pkg::SA_BITS-1:0] serial_addr_select_i,
    output logic [ddrl_pkg::SA_BITS-1:0] spd_addr_sel_o
);

    // =========================================================
    // pin synchronisers into the core clock
    // the command bus is synchronised bit by bit; it must be held stable
    // around the sampled cycle, a limitation of running it at core rate
    logic [ddrl_pkg::PIN_SYNC_W-1:0] pin_raw;
    logic [ddrl_pkg::PIN_SYNC_W-1:0] pin_s1_q;
    logic [ddrl_pkg::PIN_SYNC_W-1:0] pin_s2_q;
    logic s_dm, s_wdbi, s_rdbi, s_tdqs, s_vmon, s_par_en, s_ct;
    logic s_alert_low, s_temp, s_cs, s_act_n, s_par;
    logic [ddrl_pkg::SA_BITS-1:0] s_sa;
    logic [ddrl_pkg::VREF_MON_BITS-1:0] s_vref;
    logic [1:0] s_bg, s_ba;
    logic [ddrl_pkg::CA_ADDR_BITS-1:0] s_addr;

    // select and alert inverted so the all-zero reset means idle
    assign pin_raw = {mr5_dm_en_i, mr5_wdbi_en_i, mr5_rdbi_en_i, mr1_tdqs_en_i,
                      mr4_vref_mon_i, mr5_par_en_i, ct_mode_i, ~alert_i, temp_crit_i,
                      serial_addr_select_i, vref_level_i, ~ca_cs_n_i, ca_act_n_i,
                      ca_bg_i, ca_ba_i, ca_addr_i, ca_par_i};
    assign {s_dm, s_wdbi, s_rdbi, s_tdqs, s_vmon, s_par_en, s_ct, s_alert_low, s_temp,
            s_sa, s_vref, s_cs, s_act_n, s_bg, s_ba, s_addr, s_par} = pin_s2_q;

    // two flops before any logic
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    // =========================================================
    // link domain: configuration and beat capture
    // config must be settled before a burst; strobe stands still between bursts
    logic [ddrl_pkg::LINK_SYNC_W-1:0] lk_s1_q;
    logic [ddrl_pkg::LINK_SYNC_W-1:0] lk_s2_q;
    logic lk_dm, lk_wdbi, lk_tdqs, lk_crc;
    wire lk_dm_act;
    wire lk_wdbi_act;

    assign {lk_dm, lk_wdbi, lk_tdqs, lk_crc} = lk_s2_q;
    // mask absent on by-4 and when the by-8 pin serves as termination strobe
    assign lk_dm_act = lk_dm && (W != 4) && !((W == 8) && lk_tdqs);
    // mask and write inversion share a pin; mask wins if both are set
    assign lk_wdbi_act = lk_wdbi && !lk_dm_act && !((W == 8) && lk_tdqs);

    always_ff @(posedge dqs_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lk_s1_q <= '0;
            lk_s2_q <= '0;
        end else begin
            lk_s1_q <= {mr5_dm_en_i, mr5_wdbi_en_i, mr1_tdqs_en_i, wr_crc_en_i};
            lk_s2_q <= lk_s1_q;
        end
    end

    // even beat and its mask on the rising strobe edge
    logic [W-1:0] ev_dq_q;
    logic [NL-1:0] ev_dm_q;

    always_ff @(posedge dqs_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ev_dq_q <= '0;
            ev_dm_q <= '1;
        end else begin
            ev_dq_q <= dq_i;
            ev_dm_q <= dm_dbi_i;
        end
    end

    // =========================================================
    // beat conditioning helpers
    function automatic logic [W+NL-1:0] beat_fmt(input logic [W-1:0] d, input logic [NL-1:0] m,
                                                 input logic dm_act, input logic dbi_act);
        logic [W-1:0] r;
        logic [NL-1:0] keep;
        r = d;
        keep = '1;
        for (int l = 0; l < NL; l++) begin
            // each lane follows its own mask / inversion pin bit
            if (dm_act && !m[l]) begin
                keep[l] = 1'b0;
            end
            if (dbi_act && !m[l]) begin
                r[l*LW +: LW] = ~d[l*LW +: LW];
            end
        end
        return {keep, r};
    endfunction : beat_fmt

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [W-1:0] d);
        logic [7:0] r;
        logic fb;
        r = c;
        fb = 1'b0;
        for (int i = 0; i < W; i++) begin
            fb = r[7] ^ d[i];
            r = {r[6:0], 1'b0} ^ (fb ? ddrl_pkg::CRC_POLY : 8'h00);
        end
        return r;
    endfunction : crc_step

    // =========================================================
    // link domain: pair processing on the falling strobe edge
    logic [2:0] pair_q;
    logic [7:0] crc_q;
    logic done_tgl_q;
    logic crc_err_q;
    wire [2:0] last_pair;
    wire in_data;
    wire [PDW-1:0] pair_word;
    wire [7:0] crc_rx;
    wire [7:0] crc_next;

    // crc adds one beat pair after the data beats
    assign last_pair = 3'(ddrl_pkg::DATA_PAIRS - 1 + (lk_crc ? ddrl_pkg::CRC_PAIRS : 0));
    assign in_data = (pair_q < 3'(ddrl_pkg::DATA_PAIRS));
    assign pair_word = {beat_fmt(dq_i, dm_dbi_i, lk_dm_act, lk_wdbi_act),
                        beat_fmt(ev_dq_q, ev_dm_q, lk_dm_act, lk_wdbi_act)};
    assign crc_next = crc_step(crc_step(crc_q, ev_dq_q), dq_i);
    // a by-4 lane carries the code over two beats
    assign crc_rx = (W >= 8) ? 8'(ev_dq_q) : 8'({dq_i, ev_dq_q});

    always_ff @(negedge dqs_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pair_q <= '0;
            crc_q <= ddrl_pkg::CRC_INIT;
            done_tgl_q <= 1'b0;
            crc_err_q <= 1'b0;
        end else if (pair_q >= last_pair) begin
            pair_q <= '0;
            crc_q <= ddrl_pkg::CRC_INIT;
            done_tgl_q <= ~done_tgl_q;
            // the error flag stays put until the next burst ends
            crc_err_q <= lk_crc && (crc_rx != (in_data ? crc_next : crc_q));
        end else begin
            pair_q <= pair_q + 3'd1;
            crc_q <= in_data ? crc_next : crc_q;
        end
    end

    ddrl_pair_mem #(
        .DW(PDW),
        .AW(ddrl_pkg::PAIR_AW)
    ) u_pair_mem (
        .wclk_i(dqs_clk_i),
        .we_i(in_data),
        .waddr_i(pair_q[ddrl_pkg::PAIR_AW-1:0]),
        .wdata_i(pair_word),
        .rclk_i(clk_sys_i),
        .rarst_n_i(arst_n_i),
        .raddr_i(wr_pair_addr_i),
        .rdata_o(wr_pair_data_o)
    );

    // =========================================================
    // burst-done crossing: toggle, two flops, edge register
    logic [2:0] done_sync_q;
    logic wr_done_q;
    logic wr_crc_err_q;
    wire done_pulse;

    // the error level is stable well before the toggle arrives
    assign done_pulse = done_sync_q[2] ^ done_sync_q[1];

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            done_sync_q <= '0;
            wr_done_q <= 1'b0;
            wr_crc_err_q <= 1'b0;
        end else begin
            done_sync_q <= {done_sync_q[1:0], done_tgl_q};
            wr_done_q <= done_pulse;
            if (done_pulse) begin
                wr_crc_err_q <= crc_err_q;
            end
        end
    end

    assign wr_done_o = wr_done_q;
    assign wr_crc_err_o = wr_crc_err_q;

    // =========================================================
    // command parity check
    wire par_bad;
    wire cmd_take;
    ddrl_pkg::ddrl_alert_st_t al_st_q, al_st_d;
    logic cmd_valid_q;
    logic par_err_q;

    // even parity: the parity bit makes the total count of ones even
    assign par_bad = s_par_en && s_cs && (^{s_act_n, s_bg, s_ba, s_addr, s_par});
    assign cmd_take = s_cs && !par_bad && (al_st_q != ddrl_pkg::AL_PAR);

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmd_valid_q <= 1'b0;
            par_err_q <= 1'b0;
        end else begin
            cmd_valid_q <= cmd_take;
            par_err_q <= par_bad;
        end
    end

    assign cmd_valid_o = cmd_valid_q;
    assign par_err_o = par_err_q;

    // =========================================================
    // alert pin control
    logic [ddrl_pkg::ALERT_CNT_W-1:0] al_cnt_q, al_cnt_d;
    logic alert_oe_n_q;
    logic alert_seen_q;
    wire crc_evt;

    assign crc_evt = done_pulse && crc_err_q;

    // parity hold outranks a crc pulse; a new error during a parity hold does not restart the wait
    always_comb begin
        al_st_d = al_st_q;
        al_cnt_d = al_cnt_q;
        case (al_st_q)
            ddrl_pkg::AL_IDLE: begin
                if (par_bad) begin
                    al_st_d = ddrl_pkg::AL_PAR;
                    al_cnt_d = ddrl_pkg::ALERT_CNT_W'(RECOV_CYC - 1);
                end else if (crc_evt) begin
                    al_st_d = ddrl_pkg::AL_CRC;
                    al_cnt_d = ddrl_pkg::ALERT_CNT_W'(ALERT_CYC - 1);
                end
            end
            ddrl_pkg::AL_CRC: begin
                if (par_bad) begin
                    al_st_d = ddrl_pkg::AL_PAR;
                    al_cnt_d = ddrl_pkg::ALERT_CNT_W'(RECOV_CYC - 1);
                end else if (al_cnt_q == '0) begin
                    al_st_d = ddrl_pkg::AL_IDLE;
                end else begin
                    al_cnt_d = al_cnt_q - 1'b1;
                end
            end
            ddrl_pkg::AL_PAR: begin
                // recovery of the failed command runs out on this count
                if (al_cnt_q == '0) begin
                    al_st_d = ddrl_pkg::AL_IDLE;
                end else begin
                    al_cnt_d = al_cnt_q - 1'b1;
                end
            end
            default: begin
                al_st_d = ddrl_pkg::AL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            al_st_q <= ddrl_pkg::AL_IDLE;
            al_cnt_q <= '0;
            alert_oe_n_q <= ddrl_pkg::OE_N_RESET;
            alert_seen_q <= 1'b0;
        end else begin
            al_st_q <= al_st_d;
            al_cnt_q <= al_cnt_d;
            // in test mode the pin is released and only watched
            alert_oe_n_q <= s_ct || (al_st_d == ddrl_pkg::AL_IDLE);
            alert_seen_q <= s_ct && s_alert_low;
        end
    end

    assign alert_o = 1'b0;
    assign alert_oe_n_o = alert_oe_n_q;
    assign alert_seen_o = alert_seen_q;

    // =========================================================
    // read drive with optional inversion
    logic [W-1:0] rd_dq_q;
    logic [NL-1:0] rd_dbi_q;
    logic [NL-1:0] dqs_q;
    logic rd_oe_n_q;
    logic [W-1:0] rd_dq_d;
    logic [NL-1:0] rd_dbi_d;
    wire rd_dbi_act;

    assign rd_dbi_act = s_rdbi && (W != 4) && !((W == 8) && s_tdqs);

    // invert a lane when more than half its bits are zero, to save drive
    always_comb begin
        rd_dq_d = rd_data_i;
        rd_dbi_d = '1;
        for (int l = 0; l < NL; l++) begin
            if (rd_dbi_act && ($countones(rd_data_i[l*LW +: LW]) < (LW / 2))) begin
                rd_dq_d[l*LW +: LW] = ~rd_data_i[l*LW +: LW];
                rd_dbi_d[l] = 1'b0;
            end
        end
    end

    // strobe toggles on the same edge the data changes: edge aligned
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_dq_q <= '0;
            rd_dbi_q <= '1;
            dqs_q <= {NL{ddrl_pkg::DQS_RESET}};
            rd_oe_n_q <= ddrl_pkg::OE_N_RESET;
        end else begin
            rd_oe_n_q <= !rd_valid_i;
            if (rd_valid_i) begin
                rd_dq_q <= rd_dq_d;
                rd_dbi_q <= rd_dbi_d;
                dqs_q <= ~dqs_q;
            end else begin
                dqs_q <= {NL{ddrl_pkg::DQS_RESET}};
            end
        end
    end

    // complement always driven with the true strobe; no single-ended mode
    assign dqs_t_o = dqs_q;
    assign dqs_c_o = ~dqs_q;
    assign dqs_oe_n_o = rd_oe_n_q;
    assign dm_dbi_o = rd_dbi_q;
    assign dm_dbi_oe_n_o = rd_oe_n_q || !rd_dbi_act;

    // =========================================================
    // vref monitor on the low data lines, outside reads
    localparam int unsigned VMB = (W < ddrl_pkg::VREF_MON_BITS) ? W : ddrl_pkg::VREF_MON_BITS;
    logic vmon_q;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            vmon_q <= 1'b0;
        end else begin
            vmon_q <= s_vmon && !rd_valid_i;
        end
    end

    // monitoring lengthens training on the host side; nothing to time here
    always_comb begin
        dq_o = rd_dq_q;
        dq_oe_n_o = {W{rd_oe_n_q}};
        if (vmon_q) begin
            dq_o[VMB-1:0] = s_vref[VMB-1:0];
            dq_oe_n_o[VMB-1:0] = '0;
        end
    end

    // =========================================================
    // temperature event and spd address select
    logic event_n_q;
    logic [ddrl_pkg::SA_BITS-1:0] sa_q;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            event_n_q <= ddrl_pkg::EVENT_N_RESET;
            sa_q <= '0;
        end else begin
            event_n_q <= !s_temp;
            sa_q <= s_sa;
        end
    end

    assign event_n_o = event_n_q;
    assign spd_addr_sel_o = sa_q;

endmodule : ddrl_lane

// [verif/ddrl_host_model.sv]
// host side write link model driving strobe, data and mask
`timescale 1ns/1ns
module ddrl_host_model (
    // write link toward the lane
    output logic dqs_clk_o,
    output logic [7:0] dq_o,
    output logic dm_o
);
    // strobe stands still between bursts
    initial begin
        dqs_clk_o = 1'b0;
        dq_o = 8'h00;
        dm_o = 1'b1;
    end
    // data leads each strobe edge by 1 ns
    task automatic burst(input logic [79:0] d, input logic [9:0] m, input int n);
        for (int b = 0; b < n; b++) begin
            dq_o = d[b*8+:8];
            dm_o = m[b];
            #1 dqs_clk_o = ~dqs_clk_o;
            #2;
        end
        dq_o = ~dq_o; // released lines must not look like a stale beat
        dm_o = ~dm_o;
    endtask : burst
endmodule : ddrl_host_model

// [verif/ddrl_lane_monitor.sv]
// concurrent checks on the ddr4 data lane ports
`timescale 1ns/1ns
module ddrl_lane_monitor #(
    parameter int unsigned W = 8,
    parameter int unsigned ALERT_CYC = 6,
    parameter int unsigned RECOV_CYC = 16,
    localparam int unsigned NL = (W == 16) ? 2 : 1
) (
    // clock, reset and inputs
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic rd_valid_i,
    input wire logic ct_mode_i,
    input wire logic temp_crit_i,
    // outputs
    input wire logic wr_done_o,
    input wire logic wr_crc_err_o,
    input wire logic [NL-1:0] dqs_t_o,
    input wire logic [NL-1:0] dqs_c_o,
    input wire logic dqs_oe_n_o,
    input wire logic cmd_valid_o,
    input wire logic par_err_o,
    input wire logic alert_oe_n_o,
    input wire logic event_n_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    logic [7:0] lo_q;
    logic [7:0] lo_d;
    // cycles the alert has been held low
    assign lo_d = alert_oe_n_o ? 8'h00 : lo_q + 8'h01;
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) lo_q <= 8'h00;
        else lo_q <= lo_d;
    end
    sequence s_crc_fault;
        wr_done_o && wr_crc_err_o && !ct_mode_i && !par_err_o;
    endsequence
    sequence s_par_fault;
        par_err_o && !ct_mode_i;
    endsequence
    a_done_single: assert property (wr_done_o |=> !wr_done_o)
        else $error("done pulse too long");
    a_crc_alert_low: assert property (s_crc_fault |-> !alert_oe_n_o)
        else $error("no alert on crc error");
    a_alert_pulse_width: assert property ($rose(alert_oe_n_o) |-> lo_q == ALERT_CYC || lo_q == RECOV_CYC)
        else $error("alert low time wrong");
    a_par_alert_hold: assert property (s_par_fault |-> !alert_oe_n_o && !cmd_valid_o)
        else $error("parity error handling wrong");
    a_ct_pin_input: assert property (ct_mode_i && $past(ct_mode_i, 3) |-> alert_oe_n_o)
        else $error("alert driven in test mode");
    a_dqs_diff_pair: assert property (dqs_c_o == ~dqs_t_o)
        else $error("strobe pair not complementary");
    a_rd_strobe_edge: assert property (rd_valid_i |=> !dqs_oe_n_o && dqs_t_o == ~$past(dqs_t_o))
        else $error("no strobe edge on read");
    a_rd_strobe_idle: assert property (!rd_valid_i |=> dqs_oe_n_o && dqs_t_o == {NL{1'b0}})
        else $error("strobe still driven after read");
    a_event_on: assert property (temp_crit_i [*5] |-> !event_n_o)
        else $error("event missing");
    a_event_off: assert property (!temp_crit_i [*5] |-> event_n_o)
        else $error("spurious event");
endmodule : ddrl_lane_monitor
bind ddrl_lane ddrl_lane_monitor #(.W(W), .ALERT_CYC(ALERT_CYC), .RECOV_CYC(RECOV_CYC)) u_mon (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .rd_valid_i(rd_valid_i), .ct_mode_i(ct_mode_i),
    .temp_crit_i(temp_crit_i), .wr_done_o(wr_done_o), .wr_crc_err_o(wr_crc_err_o), .dqs_t_o(dqs_t_o),
    .dqs_c_o(dqs_c_o), .dqs_oe_n_o(dqs_oe_n_o), .cmd_valid_o(cmd_valid_o), .par_err_o(par_err_o),
    .alert_oe_n_o(alert_oe_n_o), .event_n_o(event_n_o)
);

// [verif/ddrl_lane_tb.sv]
// self-checking bench for the ddr4 data lane and alert logic
`timescale 1ns/1ns
module ddrl_lane_tb;
    // ====================
    // signals
    localparam int unsigned AC = 2; // short alert widths keep the run brief
    localparam int unsigned RC = 4;
    logic clk_sys_i = 1'b0, arst_n_i = 1'b0, mdm = 1'b0, mwd = 1'b0, mrd = 1'b0, mtd = 1'b0, crc = 1'b0;
    logic vmon = 1'b0, pen = 1'b1, ctm = 1'b0, rdv = 1'b0, cs_n = 1'b1, act_n = 1'b1, par = 1'b0;
    logic alr = 1'b1, tcr = 1'b0, dqs_clk, dm_in, dbi_o, dbi_oe_n, dqs_t, dqs_oe_n, done, cerr;
    logic cmdv, perr, al_o, aoe_n, alseen, ev_n, al_pin;
    logic [7:0] rdd = 8'h00, dq_in, dq_o, dq_oe_n;
    logic [3:0] vref = 4'h0;
    logic [2:0] sas = 3'h0, spd;
    logic [16:0] addr = 17'h00000;
    logic [1:0] pa = 2'h0;
    logic [17:0] pdata;
    int n_fail = 0;
    int checks_done = 0;
    // open-drain alert pin
    assign al_pin = (aoe_n ? 1'b1 : al_o) & alr;
    always #50 clk_sys_i = ~clk_sys_i;
    ddrl_lane #(.W(8), .ALERT_CYC(AC), .RECOV_CYC(RC)) uut (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .dqs_clk_i(dqs_clk), .dq_i(dq_in), .dq_o(dq_o),
        .dq_oe_n_o(dq_oe_n), .dm_dbi_i(dm_in), .dm_dbi_o(dbi_o), .dm_dbi_oe_n_o(dbi_oe_n), .dqs_t_o(dqs_t),
        .dqs_c_o(), .dqs_oe_n_o(dqs_oe_n), .mr5_dm_en_i(mdm), .mr5_wdbi_en_i(mwd), .mr5_rdbi_en_i(mrd),
        .mr1_tdqs_en_i(mtd), .wr_crc_en_i(crc), .mr4_vref_mon_i(vmon), .vref_level_i(vref),
        .mr5_par_en_i(pen), .ct_mode_i(ctm), .rd_valid_i(rdv), .rd_data_i(rdd), .wr_done_o(done),
        .wr_crc_err_o(cerr), .wr_pair_addr_i(pa), .wr_pair_data_o(pdata), .ca_cs_n_i(cs_n),
        .ca_act_n_i(act_n), .ca_bg_i(2'h0), .ca_ba_i(2'h0), .ca_addr_i(addr), .ca_par_i(par),
        .cmd_valid_o(cmdv), .par_err_o(perr), .alert_i(al_pin), .alert_o(al_o), .alert_oe_n_o(aoe_n),
        .alert_seen_o(alseen), .temp_crit_i(tcr), .event_n_o(ev_n), .serial_addr_select_i(sas),
        .spd_addr_sel_o(spd)
    );
    ddrl_host_model host (.dqs_clk_o(dqs_clk), .dq_o(dq_in), .dm_o(dm_in));
    // ====================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #5;
    endtask : tick
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    function automatic logic [7:0] crc8(input logic [63:0] d);
        logic [7:0] c;
        c = ddrl_pkg::CRC_INIT;
        for (int i = 0; i < 64; i++) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? ddrl_pkg::CRC_POLY : 8'h00);
        return c;
    endfunction : crc8
    // one burst, then wait for done
    task automatic wr_run(input logic [79:0] d, input logic [9:0] m, input int n);
        logic got;
        got = 1'b0;
        host.burst(d, m, n);
        for (int i = 0; i < 8 && !got; i++) begin
            @(posedge clk_sys_i);
            #1 got = (done === 1'b1);
        end
        #4 chk("wr_done", got, 1'b1);
    endtask : wr_run
    // warm-up burst lets mode bits cross
    task automatic wr_pairs(input logic [63:0] d, input logic [7:0] m, input logic inv);
        logic k;
        logic [7:0] v;
        wr_run({16'h0000, d}, {2'b11, m}, 8);
        wr_run({16'h0000, d}, {2'b11, m}, 8);
        for (int b = 0; b < 8; b++) begin
            pa = b[2:1];
            tick(1);
            k = inv | mtd | m[b];
            v = (inv && !m[b]) ? ~d[b*8+:8] : d[b*8+:8];
            chk("pair", {pdata[b%2*9+8], pdata[b%2*9+:8] & {8{k}}}, {k, v & {8{k}}});
        end
    endtask : wr_pairs
    // ====================
    // scenarios
    task automatic s_mask;
        mdm = 1'b1;
        wr_pairs(64'h8877665544332211, 8'hbd, 1'b0);
        mtd = 1'b1;
        wr_pairs(64'h1122334455667788, 8'hbd, 1'b0);
        mtd = 1'b0;
        mdm = 1'b0;
    endtask : s_mask
    task automatic s_inv;
        mwd = 1'b1;
        wr_pairs(64'h0f0ff0f05a5aa5a5, 8'h5a, 1'b1);
        mwd = 1'b0;
    endtask : s_inv
    task automatic s_crc;
        logic [79:0] f;
        f = {8'h00, crc8(64'h0123456789abcdef), 64'h0123456789abcdef};
        crc = 1'b1;
        wr_run(f, 10'h3ff, 10);
        tick(8);
        wr_run(f, 10'h3ff, 10);
        chk("crc_good", {cerr, aoe_n}, 2'b01);
        tick(8);
        wr_run(f ^ {8'h00, 8'hff, 64'h0}, 10'h3ff, 10);
        chk("crc_bad", {cerr, aoe_n}, 2'b10);
        tick(AC - 1);
        chk("crc_pulse", aoe_n, 1'b0);
        tick(1);
        chk("crc_release", aoe_n, 1'b1);
        crc = 1'b0;
    endtask : s_crc
    task automatic s_read;
        mrd = 1'b1;
        tick(2); // mode pin sync
        rdv = 1'b1;
        rdd = 8'h01;
        tick(1);
        chk("rd_beat0", {dq_o, dq_oe_n, dbi_o, dbi_oe_n, dqs_t, dqs_oe_n}, {8'hfe, 8'h00, 4'h2});
        rdd = 8'h0f;
        tick(1);
        chk("rd_beat1", {dq_o, dbi_o, dqs_t, dqs_oe_n}, {8'h0f, 3'h4});
        rdv = 1'b0;
        tick(1);
        chk("rd_idle", {dqs_t, dqs_oe_n}, 2'b01);
        mrd = 1'b0;
    endtask : s_read
    // pins held three cycles; outputs counted
    task automatic s_ca(input logic c, input logic p, input int ec, input int ep, input int ea);
        int nc, np, na;
        nc = 0;
        np = 0;
        na = 0;
        {cs_n, addr, par} = {c, 17'h10001, p};
        for (int i = 0; i < 12; i++) begin
            tick(1);
            if (i == 2) cs_n = 1'b1;
            nc += (cmdv === 1'b1);
            np += (perr === 1'b1);
            na += (aoe_n === 1'b0);
        end
        chk("ca_counts", {nc[7:0], np[7:0], na[7:0]}, {ec[7:0], ep[7:0], ea[7:0]});
    endtask : s_ca
    task automatic s_misc;
        {tcr, sas, vmon, vref} = {1'b1, 3'h5, 1'b1, 4'ha};
        tick(5);
        chk("sensor", {ev_n, spd, dq_o[3:0]}, {1'b0, 3'h5, 4'ha});
        {tcr, vmon, ctm} = 3'b001;
        tick(4);
        alr = 1'b0;
        tick(4);
        chk("ct_mode", {alseen, aoe_n, ev_n}, 3'h7);
        {alr, ctm} = 2'b10;
    endtask : s_misc
    // ====================
    // main sequence and watchdog
    initial begin
        tick(4);
        chk("reset", {aoe_n, ev_n, dqs_oe_n, done, spd}, 7'h70);
        arst_n_i = 1'b1;
        tick(3);
        s_mask();
        s_inv();
        s_crc();
        s_read();
        s_ca(1'b0, 1'b1, 3, 0, 0);
        s_ca(1'b0, 1'b0, 0, 3, RC);
        s_ca(1'b1, 1'b0, 0, 0, 0);
        s_misc();
        test_done();
    end
    initial begin
        #100000;
        n_fail++;
        test_done();
    end
endmodule : ddrl_lane_tb
